// ===== logic/pscd_top.sv
// Pin-strap configuration decoder with result serialiser and Wishbone register slave.
// Assumes conversion inputs arrive on clk_i (the master clock); straps and sync_in_n_i are synchronised.
`timescale 1ns/100ps
`default_nettype none
module pscd_top
  import pscd_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic                      wb_ack_o,
  output logic                      irq_o,
  input  wire logic                 ctrl_select_i,
  input  wire logic                 filter_select_i,
  input  wire logic                 decim_select_hi_i,
  input  wire logic                 decim_select_lo_i,
  input  wire logic [3:0]           op_select_pins_i,
  input  wire logic [1:0]           output_format_pins_i,
  input  wire logic                 standby_bank_lo_i,
  input  wire logic                 standby_bank_hi_i,
  input  wire logic                 start_n_i,
  input  wire logic                 sync_in_n_i,
  input  wire logic                 supply_fault_i,
  input  wire logic [NCH*RES_W-1:0] result_i,
  input  wire logic                 result_valid_i,
  input  wire logic [NCH-1:0]       unsettled_i,
  input  wire logic [NCH-1:0]       saturated_i,
  input  wire logic                 crc_err_i,
  input  wire logic                 map_flip_i,
  input  wire logic                 clk_missing_i,
  output logic                      pin_mode_o,
  output logic                      filter_sinc5_o,
  output logic [10:0]               decim_ratio_o,
  output logic [1:0]                power_mode_o,
  output logic [5:0]                mod_div_o,
  output logic                      mod_clk_en_o,
  output logic                      one_shot_o,
  output logic [3:0]                data_clock_divider_o,
  output logic                      ain_precharge_o,
  output logic                      ref_precharge_o,
  output logic [NCH-1:0]            chan_standby_o,
  output logic                      frame_busy_o,
  output logic                      data_output_clock_o,
  output logic [NCH-1:0]            serial_result_outputs_o
);
  localparam int NSTRAP = 13;
  localparam int BITW   = $clog2(SLOT_W);
  localparam int CHW    = $clog2(NCH);

  if (NCH != 8) begin : g_chk
    $error("pscd_top serves exactly eight channels in two standby banks");
  end

  // Strap synchronisation and decode
  logic [NSTRAP-1:0] strap_s;
  pscd_cfg_if        cfg ();

  pscd_sync #(.W(NSTRAP)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({ctrl_select_i, filter_select_i, decim_select_hi_i, decim_select_lo_i,
             op_select_pins_i, output_format_pins_i, standby_bank_lo_i, standby_bank_hi_i,
             start_n_i}),
    .q_o   (strap_s)
  );

  logic sync_in_s;
  pscd_sync #(.W(1)) u_sync_in (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sync_in_n_i),
    .q_o   (sync_in_s)
  );

  pscd_decode u_dec (
    .filter_select_i      (strap_s[11]),
    .decim_select_i       (strap_s[10:9]),
    .op_select_pins_i     (strap_s[8:5]),
    .output_format_pins_i (strap_s[4:3]),
    .standby_bank_lo_i    (strap_s[2]),
    .standby_bank_hi_i    (strap_s[1]),
    .cfg                  (cfg)
  );

  // Wishbone slave
  logic           ack_r;
  logic [31:0]    rdat_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  wire            wb_req    = wb_cyc_i & wb_stb_i & ~ack_r;
  wire            wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
  wire            hit_ctrl  = (wb_adr_i == REG_CTRL);
  wire            hit_cfg   = (wb_adr_i == REG_CFG);
  wire            hit_stat  = (wb_adr_i == REG_IRQ_STAT);
  wire            hit_mask  = (wb_adr_i == REG_IRQ_MASK);
  wire            soft_rst  = wb_wr & hit_ctrl & wb_dat_i[CTRL_SOFT_RST];
  wire            sw_resync = wb_wr & hit_ctrl & wb_dat_i[CTRL_RESYNC];
  wire            stat_rd   = wb_req & ~wb_we_i & hit_stat;

  // Control mode strap catch and reload sequencing
  logic       mode_caught_r;
  logic       spi_mode_r;
  logic       load_pend_r;
  logic       start_d_r;
  logic       sync_d_r;
  logic       err_r;
  wire        start_fall = start_d_r & ~strap_s[0];
  wire        sync_fall  = sync_d_r & ~sync_in_s;
  wire        resync_evt = start_fall | sync_fall | sw_resync;
  wire        reload     = load_pend_r | soft_rst | supply_fault_i;
  wire        err_in     = crc_err_i | map_flip_i | clk_missing_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_caught_r <= 1'b0;
      spi_mode_r    <= 1'b0;
      load_pend_r   <= 1'b1;
      start_d_r     <= 1'b1;
      sync_d_r      <= 1'b1;
    end else begin
      // Synchroniser follows the pins in reset, so the first level is real
      mode_caught_r <= 1'b1;
      if (!mode_caught_r) spi_mode_r <= strap_s[12];
      load_pend_r   <= ~mode_caught_r | soft_rst;
      start_d_r     <= strap_s[0];
      sync_d_r      <= sync_in_s;
    end
  end

  // Active configuration
  logic           act_sinc5_r;
  logic [10:0]    act_decim_r;
  pscd_pwr_e      act_pwr_r;
  logic [3:0]     act_div_r;
  logic [5:0]     act_moddiv_r;
  logic           act_one_r;
  logic [NCH-1:0] act_stby_r;
  logic [1:0]     act_fmt_r;
  wire            pin_mode = mode_caught_r & ~spi_mode_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst || (spi_mode_r && mode_caught_r)) begin
      // Low-current defaults until straps are taken up
      act_sinc5_r  <= 1'b1;
      act_decim_r  <= DEC_1024;
      act_pwr_r    <= PSCD_PWR_LOW;
      act_div_r    <= DIV_8;
      act_moddiv_r <= MODDIV_LOW;
      act_one_r    <= 1'b0;
      act_stby_r   <= '0;
      act_fmt_r    <= 2'h0;
    end else if (pin_mode && (reload || resync_evt)) begin
      act_sinc5_r  <= cfg.filt_sinc5;
      act_decim_r  <= cfg.decim;
      act_pwr_r    <= cfg.pwr;
      act_div_r    <= cfg.data_clock_divider;
      act_moddiv_r <= cfg.mod_div;
      act_one_r    <= cfg.one_shot;
      act_stby_r   <= cfg.standby;
      act_fmt_r    <= cfg.format;
    end
  end

  // Sticky error; only a reset of either kind clears it
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) err_r <= 1'b0;
    else if (err_in)       err_r <= 1'b1;
  end

  // Modulator clock enable
  logic [5:0] mod_cnt_r;
  logic       mod_en_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || resync_evt) begin
      mod_cnt_r <= '0;
      mod_en_r  <= 1'b0;
    end else begin
      mod_en_r  <= (mod_cnt_r == act_moddiv_r - 6'h01);
      mod_cnt_r <= (mod_cnt_r == act_moddiv_r - 6'h01) ? '0 : mod_cnt_r + 6'h01;
    end
  end

  // Result serialiser, independent of the register bus
  logic [SLOT_W-1:0] frame_r [NCH];
  logic              busy_r;
  logic [BITW-1:0]   bit_r;
  logic [CHW-1:0]    slot_r;
  logic [2:0]        hp_cnt_r;
  logic              data_output_clock_r;
  logic              data_output_clock_q_r;
  logic [NCH-1:0]    dout_r;
  logic              frame_done;
  wire  [CHW:0]      per_line  = (act_fmt_r == 2'h0) ? 4'h1 :
                                 (act_fmt_r == 2'h1) ? 4'h4 : 4'h8;
  wire  [2:0]        half_last = (act_div_r == DIV_1) ? 3'h0 : 3'(act_div_r[3:1] - 3'h1);
  wire               hp_wrap   = (hp_cnt_r == half_last);
  wire               last_bit  = (bit_r == BITW'(SLOT_W - 1));
  wire               last_slot = ({1'b0, slot_r} == per_line - 4'h1);
  assign frame_done = busy_r & hp_wrap & data_output_clock_r & last_bit & last_slot;

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (rst_i) begin
        frame_r[c] <= '0;
      end else if (result_valid_i && !busy_r) begin
        frame_r[c] <= act_stby_r[c] ? '0 :
                      {err_r, unsettled_i[c], act_sinc5_r, saturated_i[c], 1'b0,
                       3'(c), result_i[c*RES_W +: RES_W]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r   <= 1'b0;
      bit_r    <= '0;
      slot_r   <= '0;
      hp_cnt_r <= '0;
      data_output_clock_r   <= 1'b0;
    end else if (!busy_r) begin
      busy_r   <= result_valid_i;
      bit_r    <= '0;
      slot_r   <= '0;
      hp_cnt_r <= '0;
      data_output_clock_r   <= 1'b0;
    end else if (hp_wrap) begin
      hp_cnt_r <= '0;
      data_output_clock_r   <= ~data_output_clock_r;
      if (data_output_clock_r) begin
        if (last_bit) begin
          bit_r  <= '0;
          slot_r <= slot_r + CHW'(1);
          busy_r <= ~last_slot;
        end else begin
          bit_r  <= bit_r + BITW'(1);
        end
      end
    end else begin
      hp_cnt_r <= hp_cnt_r + 3'h1;
    end
  end

  // Line k carries slots k*per_line .. k*per_line+per_line-1, MSB first
  for (genvar k = 0; k < NCH; k++) begin : g_line
    wire [CHW+3:0] ch_full = (CHW+4)'(k) * (CHW+4)'(per_line) + (CHW+4)'(slot_r);
    wire           used    = ((CHW+4)'(k) < (CHW+4)'(NCH) / (CHW+4)'(per_line));
    wire           bit_val = frame_r[ch_full[CHW-1:0]][BITW'(SLOT_W - 1) - bit_r];
    always_ff @(posedge clk_i) begin
      if (rst_i) dout_r[k] <= 1'b0;
      else       dout_r[k] <= busy_r & used & bit_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) data_output_clock_q_r <= 1'b0;
    else       data_output_clock_q_r <= busy_r & data_output_clock_r;
  end

  // Interrupts: set wins over the read-clear
  wire [IRQ_W-1:0] irq_set = {frame_done, err_in & ~err_r, resync_evt & pin_mode};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (stat_rd ? '0 : irq_stat_r) | irq_set;
      if (wb_wr && hit_mask) irq_mask_r <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Read mux; unmapped addresses answer zero
  wire [31:0] cfg_word = (32'(act_decim_r) << CFG_DEC) | (32'(act_div_r) << CFG_DIV) |
                         (32'(act_pwr_r) << CFG_PWR) | (32'(err_r) << CFG_ERR) |
                         (32'(act_one_r) << CFG_ONE) | (32'(act_sinc5_r) << CFG_FILT) |
                         (32'(pin_mode) << CFG_PIN);
  wire [31:0] rd_mux   = hit_cfg  ? cfg_word :
                         hit_stat ? 32'(irq_stat_r) :
                         hit_mask ? 32'(irq_mask_r) : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r  <= wb_req;
      rdat_r <= (wb_req && !wb_we_i) ? rd_mux : '0;
    end
  end

  assign wb_ack_o                = ack_r;
  assign wb_dat_o                = rdat_r;
  assign irq_o                   = |(irq_stat_r & irq_mask_r);
  assign pin_mode_o              = pin_mode;
  assign filter_sinc5_o          = act_sinc5_r;
  assign decim_ratio_o           = act_decim_r;
  assign power_mode_o            = act_pwr_r;
  assign mod_div_o               = act_moddiv_r;
  assign mod_clk_en_o            = mod_en_r;
  assign one_shot_o              = act_one_r;
  assign data_clock_divider_o    = act_div_r;
  assign ain_precharge_o         = 1'b1;
  assign ref_precharge_o         = 1'b0;
  assign chan_standby_o          = act_stby_r;
  assign frame_busy_o            = busy_r;
  assign data_output_clock_o     = data_output_clock_q_r;
  assign serial_result_outputs_o = dout_r;
endmodule : pscd_top
`default_nettype wire

// ===== logic/pscd_pkg.sv
// Shared constants, types and decode functions for the strap configuration decoder.
// Assumes a single master clock domain; no timing constants are needed.
package pscd_pkg;

  localparam int NCH    = 8;
  localparam int HDR_W  = 8;
  localparam int RES_W  = 16;
  localparam int SLOT_W = HDR_W + RES_W;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CFG      = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

  // Control register bits
  localparam int CTRL_SOFT_RST = 0;
  localparam int CTRL_RESYNC   = 1;

  // Interrupt status layout
  localparam int IRQ_W      = 3;
  localparam int IRQ_RESYNC = 0;
  localparam int IRQ_ERR    = 1;
  localparam int IRQ_FRAME  = 2;

  // Status header bit positions
  localparam int HDR_ERR       = 7;
  localparam int HDR_UNSETTLED = 6;
  localparam int HDR_FILT      = 5;
  localparam int HDR_SAT       = 4;

  // Config register field positions
  localparam int CFG_PIN   = 0;
  localparam int CFG_FILT  = 1;
  localparam int CFG_ONE   = 2;
  localparam int CFG_ERR   = 3;
  localparam int CFG_PWR   = 4;
  localparam int CFG_DIV   = 8;
  localparam int CFG_DEC   = 16;

  localparam logic [10:0] DEC_32   = 11'h020;
  localparam logic [10:0] DEC_64   = 11'h040;
  localparam logic [10:0] DEC_128  = 11'h080;
  localparam logic [10:0] DEC_1024 = 11'h400;

  localparam logic [5:0] MODDIV_FAST = 6'h04;
  localparam logic [5:0] MODDIV_MED  = 6'h08;
  localparam logic [5:0] MODDIV_LOW  = 6'h20;

  localparam logic [3:0] DIV_1 = 4'h1;
  localparam logic [3:0] DIV_2 = 4'h2;
  localparam logic [3:0] DIV_4 = 4'h4;
  localparam logic [3:0] DIV_8 = 4'h8;

  localparam logic [3:0] OP_ONESHOT_MIN = 4'hc;

  typedef enum logic [1:0] {
    PSCD_PWR_LOW,
    PSCD_PWR_MED,
    PSCD_PWR_FAST
  } pscd_pwr_e;

  function automatic logic [10:0] pscd_decim(input logic [1:0] code);
    case (code)
      2'h0:    pscd_decim = DEC_32;
      2'h1:    pscd_decim = DEC_64;
      2'h2:    pscd_decim = DEC_128;
      default: pscd_decim = DEC_1024;
    endcase
  endfunction : pscd_decim

  function automatic pscd_pwr_e pscd_pwr(input logic [3:0] op);
    case (op)
      4'h0, 4'h1, 4'h2, 4'h3, 4'hc: pscd_pwr = PSCD_PWR_LOW;
      4'h4, 4'h5, 4'h6, 4'h7, 4'hd: pscd_pwr = PSCD_PWR_MED;
      default:                      pscd_pwr = PSCD_PWR_FAST;
    endcase
  endfunction : pscd_pwr

  function automatic logic [3:0] pscd_div(input logic [3:0] op);
    if (op >= OP_ONESHOT_MIN) begin
      pscd_div = (op == 4'he) ? DIV_2 : DIV_1;
    end else begin
      case (op[1:0])
        2'h0:    pscd_div = DIV_1;
        2'h1:    pscd_div = DIV_2;
        2'h2:    pscd_div = DIV_4;
        default: pscd_div = DIV_8;
      endcase
    end
  endfunction : pscd_div

  function automatic logic [5:0] pscd_moddiv(input pscd_pwr_e p);
    case (p)
      PSCD_PWR_FAST: pscd_moddiv = MODDIV_FAST;
      PSCD_PWR_MED:  pscd_moddiv = MODDIV_MED;
      default:       pscd_moddiv = MODDIV_LOW;
    endcase
  endfunction : pscd_moddiv

endpackage : pscd_pkg

// ===== logic/pscd_cfg_if.sv
// Decoded configuration passed from the strap decoder to the top.
// Purely combinational carrier within one clock domain.
`timescale 1ns/100ps
`default_nettype none
interface pscd_cfg_if;
  import pscd_pkg::*;
  logic              filt_sinc5;
  logic [10:0]       decim;
  pscd_pwr_e         pwr;
  logic [3:0]        data_clock_divider;
  logic [5:0]        mod_div;
  logic              one_shot;
  logic [NCH-1:0]    standby;
  logic [1:0]        format;
  modport src (output filt_sinc5, decim, pwr, data_clock_divider, mod_div, one_shot, standby, format);
  modport dst (input  filt_sinc5, decim, pwr, data_clock_divider, mod_div, one_shot, standby, format);
endinterface : pscd_cfg_if
`default_nettype wire

// ===== logic/pscd_sync.sv
// Two-stage synchroniser for a bus of quasi-static strap levels.
// Bits may settle in different cycles; the decode straps are taken up only on resync or reload.
`timescale 1ns/100ps
`default_nettype none
module pscd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Follow the pins in reset: no stale level or false edge at release
      meta_r <= d_i;
      q_r    <= d_i;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule : pscd_sync
`default_nettype wire

// ===== logic/pscd_decode.sv
// Combinational decode of synchronised straps into an operating configuration.
// Straps arrive already synchronised; output is latched by the top.
`timescale 1ns/100ps
`default_nettype none
module pscd_decode
  import pscd_pkg::*;
(
  input  wire logic       filter_select_i,
  input  wire logic [1:0] decim_select_i,
  input  wire logic [3:0] op_select_pins_i,
  input  wire logic [1:0] output_format_pins_i,
  input  wire logic       standby_bank_lo_i,
  input  wire logic       standby_bank_hi_i,
  pscd_cfg_if.src         cfg
);
  localparam int HALF = NCH / 2;

  assign cfg.filt_sinc5 = filter_select_i;
  assign cfg.decim      = pscd_decim(decim_select_i);
  assign cfg.pwr        = pscd_pwr(op_select_pins_i);
  assign cfg.data_clock_divider   = pscd_div(op_select_pins_i);
  assign cfg.one_shot   = (op_select_pins_i >= OP_ONESHOT_MIN);
  assign cfg.mod_div    = pscd_moddiv(cfg.pwr);
  assign cfg.format     = output_format_pins_i;
  assign cfg.standby    = {{HALF{standby_bank_hi_i}}, {HALF{standby_bank_lo_i}}};
endmodule : pscd_decode
`default_nettype wire

// ===== sim/pscd_chk.sv
// Checker: strap decode and frame start relations seen at the top ports.
// Assumes straps are held steady for some cycles around each resync pulse.
`timescale 1ns/100ps
`default_nettype none
module pscd_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        sync_in_n_i,
  input wire logic        filter_select_i,
  input wire logic        decim_select_hi_i,
  input wire logic        decim_select_lo_i,
  input wire logic [3:0]  op_select_pins_i,
  input wire logic        standby_bank_lo_i,
  input wire logic        standby_bank_hi_i,
  input wire logic        result_valid_i,
  input wire logic        pin_mode_o,
  input wire logic        filter_sinc5_o,
  input wire logic [10:0] decim_ratio_o,
  input wire logic [1:0]  power_mode_o,
  input wire logic [5:0]  mod_div_o,
  input wire logic        one_shot_o,
  input wire logic [3:0]  data_clock_divider_o,
  input wire logic        ain_precharge_o,
  input wire logic        ref_precharge_o,
  input wire logic [7:0]  chan_standby_o,
  input wire logic        frame_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [1:0]  dec_w = {decim_select_hi_i, decim_select_lo_i};
  wire [10:0] dec_x = (dec_w == 2'h3) ? 11'h400 : (11'h020 << dec_w);
  wire [3:0]  op_w  = op_select_pins_i;
  // Sync falls; decode lands a few cycles later after the synchroniser
  sequence rs;
    $fell(sync_in_n_i) && pin_mode_o;
  endsequence
  AST_PRECHARGE: assert property (pin_mode_o |-> ain_precharge_o && !ref_precharge_o)
    else $error("precharge enables wrong");
  AST_FILTER: assert property (rs |-> ##[2:6] filter_sinc5_o == filter_select_i)
    else $error("filter not taken up");
  AST_DECIM: assert property (rs |-> ##[2:6] decim_ratio_o == dec_x)
    else $error("decimation wrong");
  AST_STD_OP: assert property (rs ##0 (op_w < 4'hc) |-> ##[2:6] (!one_shot_o &&
    power_mode_o == op_w[3:2] && data_clock_divider_o == (4'h1 << op_w[1:0])))
    else $error("standard op decode wrong");
  AST_ONE_SHOT: assert property (rs ##0 (op_w >= 4'hc) |-> ##[2:6] (one_shot_o &&
    data_clock_divider_o == ((op_w == 4'he) ? 4'h2 : 4'h1)))
    else $error("one-shot decode wrong");
  AST_MOD_DIV: assert property (mod_div_o == ((power_mode_o == 2'h2) ? 6'h04 :
    (power_mode_o == 2'h1) ? 6'h08 : 6'h20))
    else $error("modulator divide wrong");
  AST_STANDBY: assert property (rs |-> ##[2:6]
    chan_standby_o == {{4{standby_bank_hi_i}}, {4{standby_bank_lo_i}}})
    else $error("standby banks wrong");
  AST_FRAME: assert property ($rose(frame_busy_o) |->
    $past(result_valid_i) || $past(result_valid_i, 2))
    else $error("frame without result");
  cover property (rs);
  cover property (rs ##0 (op_w >= 4'hc));
  cover property ($fell(frame_busy_o));
endmodule : pscd_chk
bind pscd_top pscd_chk pscd_chk_inst (.*);
`default_nettype wire

// ===== sim/pscd_host_rx.sv
// Host receiver model: shifts every serial line on each rising data clock.
// Assumes the data clock stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module pscd_host_rx (
  input  wire logic        clk_i,
  input  wire logic        frame_i,
  input  wire logic        data_output_clock_i,
  input  wire logic [7:0]  dout_i,
  output logic      [23:0] word_o [8],
  output int               bits_o
);
  logic data_output_clock_q = 1'h0;
  logic frame_q = 1'h0;
  // Rising data clock: the bit has been settled for the whole low half
  always @(posedge clk_i) begin
    data_output_clock_q  <= data_output_clock_i;
    frame_q <= frame_i;
    if (frame_i && !frame_q) begin
      bits_o <= 0;
      for (int k = 0; k < 8; k++) word_o[k] <= 24'h0;
    end else if (data_output_clock_i && !data_output_clock_q) begin
      bits_o <= bits_o + 1;
      for (int k = 0; k < 8; k++) word_o[k] <= {word_o[k][22:0], dout_i[k]};
    end
  end
endmodule : pscd_host_rx
`default_nettype wire

// ===== sim/tb.sv
// Bench: straps, resync pins, Wishbone and result frames for the decoder.
// Assumes the host receiver model on the serial outputs.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pscd_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic ctrl_select_i = 1'h0, filter_select_i = 1'h1, decim_select_hi_i = 1'h0;
  logic decim_select_lo_i = 1'h0, standby_bank_lo_i = 1'h0, standby_bank_hi_i = 1'h0;
  logic start_n_i = 1'h1, sync_in_n_i = 1'h1, supply_fault_i = 1'h0, result_valid_i = 1'h0;
  logic crc_err_i = 1'h0, map_flip_i = 1'h0, clk_missing_i = 1'h0, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i = 8'h0, unsettled_i = 8'h20, saturated_i = 8'h40;
  logic [31:0] wb_dat_i = 32'h0, rd, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hf, op_select_pins_i = 4'h0, data_clock_divider_o;
  logic [1:0] output_format_pins_i = 2'h0, pwr, power_mode_o;
  logic [NCH*RES_W-1:0] result_i;
  logic pin_mode_o, filter_sinc5_o, mod_clk_en_o, one_shot_o, frame_busy_o;
  logic ain_precharge_o, ref_precharge_o, data_output_clock_o;
  logic [10:0] decim_ratio_o;
  logic [5:0] mod_div_o;
  logic [7:0] chan_standby_o, serial_result_outputs_o;
  logic [23:0] word [8];
  int bits, num_errors = 0, check_count = 0, ticks = 0;
  pscd_top pscd_top_inst (.*);
  pscd_host_rx pscd_host_rx_inst (.clk_i(clk_i), .frame_i(frame_busy_o),
    .data_output_clock_i(data_output_clock_o), .dout_i(serial_result_outputs_o), .word_o(word), .bits_o(bits));
  always #10 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  // Classic cycle; lane 0 must be set for a write to land
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic straps(input logic [3:0] op, input logic f, input logic [1:0] dc,
                        input logic [1:0] st);
    @(posedge clk_i);
    op_select_pins_i <= op;
    filter_select_i  <= f;
    {decim_select_hi_i, decim_select_lo_i} <= dc;
    {standby_bank_hi_i, standby_bank_lo_i} <= st;
  endtask : straps
  task automatic resync(input logic use_start);
    @(posedge clk_i);
    if (use_start) start_n_i <= 1'h0;
    else sync_in_n_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    start_n_i   <= 1'h1;
    sync_in_n_i <= 1'h1;
    repeat (8) @(posedge clk_i);
  endtask : resync
  function automatic logic [23:0] slot(input int c);
    if (c < 4) return 24'h0;
    return {1'h1, c == 5, 1'h0, c == 6, 1'h0, c[2:0], 16'ha5c0 + c[15:0]};
  endfunction : slot
  task automatic t_decode();
    logic [3:0] i;
    int n = 0;
    for (int k = 0; k < 16; k++) begin
      i = k[3:0];
      straps(i, i[0], i[1:0], i[3:2]);
      resync(i[0]);
      pwr = (i < 4'hc) ? i[3:2] : (i == 4'hc) ? 2'h0 : (i == 4'hd) ? 2'h1 : 2'h2;
      chk("filter", filter_sinc5_o, i[0]);
      chk("decim", decim_ratio_o, (i[1:0] == 2'h3) ? 32'h400 : 32'h20 << i[1:0]);
      chk("power", power_mode_o, pwr);
      chk("div", data_clock_divider_o, (i < 4'hc) ? 32'h1 << i[1:0] : 32'h1 + (i == 4'he));
      chk("one_shot", one_shot_o, i >= 4'hc);
      chk("mod_div", mod_div_o, (pwr == 2'h2) ? 32'h4 : (pwr == 2'h1) ? 32'h8 : 32'h20);
      chk("standby", chan_standby_o, {{4{i[3]}}, {4{i[2]}}});
    end
    repeat (40) begin
      @(posedge clk_i);
      n += mod_clk_en_o;
    end
    chk("mod_en", n, 32'd10);
    $display("test decode done");
  endtask : t_decode
  task automatic t_irq();
    wb(1'h1, REG_IRQ_MASK, 32'h1);
    wb(1'h1, REG_IRQ_MASK, 32'h0, 4'h0);
    straps(4'h9, 1'h0, 2'h0, 2'h1);
    repeat (10) @(posedge clk_i);
    wb(1'h0, REG_IRQ_STAT, 32'h0);
    chk("hold", {filter_sinc5_o, irq_o}, 32'h2);
    wb(1'h1, REG_CTRL, 32'h2);
    repeat (6) @(posedge clk_i);
    chk("load", {filter_sinc5_o, irq_o}, 32'h1);
    wb(1'h0, REG_IRQ_STAT, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("stat", {rd[IRQ_RESYNC], irq_o}, 32'h2);
    wb(1'h1, REG_IRQ_MASK, 32'h0);
    wb(1'h1, REG_CTRL, 32'h2);
    repeat (6) @(posedge clk_i);
    chk("masked", irq_o, 32'h0);
    wb(1'h0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test irq done");
  endtask : t_irq
  task automatic t_err();
    for (int e = 0; e < 3; e++) begin
      @(posedge clk_i);
      {clk_missing_i, map_flip_i, crc_err_i} <= 3'h1 << e;
      @(posedge clk_i);
      {clk_missing_i, map_flip_i, crc_err_i} <= 3'h0;
      wb(1'h0, REG_CFG, 32'h0);
      chk("err_set", rd[CFG_ERR], 32'h1);
      wb(1'h1, REG_CTRL, 32'h1);
      wb(1'h0, REG_CFG, 32'h0);
      chk("err_clr", rd[CFG_ERR], 32'h0);
      chk("soft_reload", filter_sinc5_o, 32'h0);
    end
    $display("test errors done");
  endtask : t_err
  // Divide by 2 puts 24 bits in 48 cycles of a 128-cycle period
  task automatic t_frame(input logic [1:0] fmt);
    logic [23:0] e;
    @(posedge clk_i);
    output_format_pins_i <= fmt;
    crc_err_i <= 1'h1;
    resync(1'h0);
    crc_err_i      <= 1'h0;
    result_valid_i <= 1'h1;
    @(posedge clk_i);
    result_valid_i <= 1'h0;
    do @(posedge clk_i); while (frame_busy_o !== 1'h1);
    do @(posedge clk_i); while (frame_busy_o !== 1'h0);
    repeat (4) @(posedge clk_i);
    chk("bits", bits, (fmt == 2'h0) ? 24 : (fmt == 2'h1) ? 96 : 192);
    for (int k = 0; k < 8; k++) begin
      e = (fmt == 2'h0) ? slot(k) : (k == 0) ? slot((fmt == 2'h1) ? 3 : 7) :
          (k == 1 && fmt == 2'h1) ? slot(7) : 24'h0;
      chk("word", word[k], e);
    end
    $display("test frame done");
  endtask : t_frame
  initial begin
    for (int c = 0; c < NCH; c++) result_i[c*RES_W +: RES_W] = 16'ha5c0 + c[15:0];
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk("pin_mode", pin_mode_o, 32'h1);
    chk("precharge", {ain_precharge_o, ref_precharge_o}, 32'h2);
    chk("strap_state", {filter_sinc5_o, decim_ratio_o, data_clock_divider_o}, 32'h8201);
    {decim_select_hi_i, supply_fault_i} <= 2'h3;
    repeat (4) @(posedge clk_i);
    supply_fault_i <= 1'h0;
    @(posedge clk_i);
    chk("fault_reload", decim_ratio_o, 32'h80);
    $display("test reset done");
    t_decode();
    t_irq();
    t_err();
    for (int f = 0; f < 3; f++) t_frame(f[1:0]);
    end_sim();
  end
endmodule : tb
`default_nettype wire
